// ===== design/io_space_regs.svh
// Offsets, bit masks and reset values of the I/O register space.
// Assumes a core that issues one byte-wide access per request.
`ifndef IO_SPACE_REGS_SVH
`define IO_SPACE_REGS_SVH

`define IO_BIT_TOP 8'h1F
`define IO_TOP 8'h3F
`define DATA_IO_OFFSET 8'h20
`define DATA_EXT_BASE 8'h60
`define DATA_EXT_TOP 8'hFF
`define EXT_DEPTH 160

`define OFS_PORT_B_PIN 6'h03
`define OFS_PORT_B_DIR 6'h04
`define OFS_PORT_B_OUT 6'h05
`define OFS_PORT_C_PIN 6'h06
`define OFS_PORT_C_DIR 6'h07
`define OFS_PORT_C_OUT 6'h08
`define OFS_PORT_D_PIN 6'h09
`define OFS_PORT_D_DIR 6'h0A
`define OFS_PORT_D_OUT 6'h0B
`define OFS_TMR0_FLAGS 6'h15
`define OFS_TMR1_FLAGS 6'h16
`define OFS_TMR2_FLAGS 6'h17
`define OFS_PCHG_FLAGS 6'h1B
`define OFS_EXTIRQ_FLAGS 6'h1C
`define OFS_EXTIRQ_MASK 6'h1D
`define OFS_SCRATCH0 6'h1E
`define OFS_EE_DATA 6'h20
`define OFS_EE_ADDR_LO 6'h21
`define OFS_EE_ADDR_HI 6'h22
`define OFS_GTIMER_CTRL 6'h23
`define OFS_TMR0_CTRL_A 6'h24
`define OFS_TMR0_CTRL_B 6'h25
`define OFS_TMR0_COUNT 6'h26
`define OFS_TMR0_CMP_A 6'h27
`define OFS_TMR0_CMP_B 6'h28
`define OFS_SCRATCH1 6'h2A
`define OFS_SCRATCH2 6'h2B
`define OFS_SPI_CTRL 6'h2C
`define OFS_SPI_STATUS 6'h2D
`define OFS_SPI_DATA 6'h2E
`define OFS_CMP_CTRL 6'h30
`define OFS_SLEEP_CTRL 6'h33
`define OFS_RESET_CAUSE 6'h34
`define OFS_CORE_MISC 6'h35

`define MASK_FULL 8'hFF
`define MASK_NONE 8'h00
`define MASK_PORT_C 8'h7F
`define MASK_TMR_FLAGS 8'h07
`define MASK_TMR1_FLAGS 8'h27
`define MASK_PCHG_FLAGS 8'h07
`define MASK_EXTIRQ 8'h03
`define MASK_GTIMER 8'h83
`define MASK_TMR0_CTRL_A 8'hF3
`define MASK_TMR0_CTRL_B 8'hCF
`define MASK_SPI_STATUS 8'hC1
`define MASK_LOW_NIBBLE 8'h0F
`define MASK_CORE_MISC 8'h73

`define REG_RESET 8'h00

`endif

// ===== design/io_space_pkg.sv
// Types shared by the I/O register space decoder and its users.
// Assumes io_space_regs.svh holds the numbers.
package io_space_pkg;

   typedef enum logic [2:0] {
      OP_IO_READ = 3'b000,
      OP_IO_WRITE = 3'b001,
      OP_BIT_SET = 3'b010,
      OP_BIT_CLEAR = 3'b011,
      OP_SKIP_IF_SET = 3'b100,
      OP_SKIP_IF_CLEAR = 3'b101,
      OP_DATA_LOAD = 3'b110,
      OP_DATA_STORE = 3'b111
   } core_op_e;

   typedef struct packed {
      logic valid;
      core_op_e op;
      logic [7:0] addr;
      logic [7:0] wdata;
      logic [2:0] bit_sel;
   } core_req_s;

   typedef struct packed {
      logic valid;
      logic [7:0] rdata;
      logic skip;
      logic refused;
   } core_rsp_s;

   typedef struct packed {
      logic [7:0] timer0;
      logic [7:0] timer1;
      logic [7:0] timer2;
      logic [7:0] pin_change;
      logic [7:0] ext_irq;
   } flag_events_s;

endpackage

// ===== design/io_register_space_decoder.sv
// I/O register space decoder: 64 I/O registers, data-space mirror, extended area.
// Assumes one core request per cycle on sys_clk_i; pins are asynchronous.
//
// Function
// - Bit set/clear only for 0x00-0x1F.
// - Skip instructions test one bit, low range.
// - Status flags clear on writing one.
// - Bit ops touch only the addressed bit.
// - I/O instructions use 6-bit addresses 0x00-0x3F.
// - Data address equals I/O address plus 0x20.
// - Extended area 0x60-0xFF by load/store only.
// - Ports: pin input, direction, output ascending.
`timescale 1ns/10ps
`include "io_space_regs.svh"

module io_register_space_decoder #(
   parameter int EXT_DEPTH = `EXT_DEPTH
) (
   input wire logic sys_clk_i, // Core clock, 250 MHz
   input wire logic resetn_i, // Synchronous reset, active low
   input wire io_space_pkg::core_req_s req_i, // Access from the core
   input wire io_space_pkg::flag_events_s flag_set_i, // One-cycle flag set events
   input wire logic [7:0] port_b_pins_i, // Port B pin levels, asynchronous
   input wire logic [7:0] port_c_pins_i, // Port C pin levels, asynchronous
   input wire logic [7:0] port_d_pins_i, // Port D pin levels, asynchronous
   output io_space_pkg::core_rsp_s rsp_o, // Answer, one cycle after request
   output logic [63:0][7:0] io_regs_o // Stored I/O register contents
);

   logic [7:0] reg_q [0:63];
   logic [7:0] ext_q [0:EXT_DEPTH-1];
   logic [7:0] pin_b_meta_q, pin_b_q;
   logic [7:0] pin_c_meta_q, pin_c_q;
   logic [7:0] pin_d_meta_q, pin_d_q;
   io_space_pkg::core_rsp_s rsp_q;

   logic io_hit, ext_hit, is_write, refused;
   logic [5:0] io_idx;
   logic [7:0] ext_idx;
   logic [7:0] wsel, wval, rd_byte, onehot;

   // Bits that exist in each I/O location; everything else is reserved
   function automatic logic [7:0] valid_mask(input logic [5:0] a);
      case (a)
         `OFS_PORT_B_PIN, `OFS_PORT_B_DIR, `OFS_PORT_B_OUT: valid_mask = `MASK_FULL;
         `OFS_PORT_C_PIN, `OFS_PORT_C_DIR, `OFS_PORT_C_OUT: valid_mask = `MASK_PORT_C;
         `OFS_PORT_D_PIN, `OFS_PORT_D_DIR, `OFS_PORT_D_OUT: valid_mask = `MASK_FULL;
         `OFS_TMR0_FLAGS, `OFS_TMR2_FLAGS: valid_mask = `MASK_TMR_FLAGS;
         `OFS_TMR1_FLAGS: valid_mask = `MASK_TMR1_FLAGS;
         `OFS_PCHG_FLAGS: valid_mask = `MASK_PCHG_FLAGS;
         `OFS_EXTIRQ_FLAGS, `OFS_EXTIRQ_MASK: valid_mask = `MASK_EXTIRQ;
         `OFS_SCRATCH0, `OFS_SCRATCH1, `OFS_SCRATCH2: valid_mask = `MASK_FULL;
         `OFS_EE_DATA, `OFS_EE_ADDR_LO, `OFS_EE_ADDR_HI: valid_mask = `MASK_FULL;
         `OFS_GTIMER_CTRL: valid_mask = `MASK_GTIMER;
         `OFS_TMR0_CTRL_A: valid_mask = `MASK_TMR0_CTRL_A;
         `OFS_TMR0_CTRL_B: valid_mask = `MASK_TMR0_CTRL_B;
         `OFS_TMR0_COUNT, `OFS_TMR0_CMP_A, `OFS_TMR0_CMP_B: valid_mask = `MASK_FULL;
         `OFS_SPI_CTRL, `OFS_SPI_DATA, `OFS_CMP_CTRL: valid_mask = `MASK_FULL;
         `OFS_SPI_STATUS: valid_mask = `MASK_SPI_STATUS;
         `OFS_SLEEP_CTRL, `OFS_RESET_CAUSE: valid_mask = `MASK_LOW_NIBBLE;
         `OFS_CORE_MISC: valid_mask = `MASK_CORE_MISC;
         default: valid_mask = `MASK_NONE;
      endcase
   endfunction

   function automatic logic is_w1c(input logic [5:0] a);
      is_w1c = (a == `OFS_TMR0_FLAGS) || (a == `OFS_TMR1_FLAGS) || (a == `OFS_TMR2_FLAGS) ||
               (a == `OFS_PCHG_FLAGS) || (a == `OFS_EXTIRQ_FLAGS);
   endfunction

   function automatic logic is_pin(input logic [5:0] a);
      is_pin = (a == `OFS_PORT_B_PIN) || (a == `OFS_PORT_C_PIN) || (a == `OFS_PORT_D_PIN);
   endfunction

   function automatic logic [7:0] hw_set(input logic [5:0] a,
                                         input io_space_pkg::flag_events_s ev);
      case (a)
         `OFS_TMR0_FLAGS: hw_set = ev.timer0;
         `OFS_TMR1_FLAGS: hw_set = ev.timer1;
         `OFS_TMR2_FLAGS: hw_set = ev.timer2;
         `OFS_PCHG_FLAGS: hw_set = ev.pin_change;
         `OFS_EXTIRQ_FLAGS: hw_set = ev.ext_irq;
         default: hw_set = `MASK_NONE;
      endcase
   endfunction

   // Pins cross into the core clock through two flops
   always_ff @(posedge sys_clk_i) begin
      if (!resetn_i) begin
         pin_b_meta_q <= `REG_RESET;
         pin_b_q <= `REG_RESET;
         pin_c_meta_q <= `REG_RESET;
         pin_c_q <= `REG_RESET;
         pin_d_meta_q <= `REG_RESET;
         pin_d_q <= `REG_RESET;
      end else begin
         pin_b_meta_q <= port_b_pins_i;
         pin_b_q <= pin_b_meta_q;
         pin_c_meta_q <= port_c_pins_i;
         pin_c_q <= pin_c_meta_q;
         pin_d_meta_q <= port_d_pins_i;
         pin_d_q <= pin_d_meta_q;
      end
   end

   // Address decode for the three instruction families
   always_comb begin
      io_hit = 1'b0;
      ext_hit = 1'b0;
      refused = 1'b0;
      io_idx = req_i.addr[5:0];
      ext_idx = req_i.addr - `DATA_EXT_BASE;
      if (!req_i.valid) begin
         refused = 1'b0;
      end else if (req_i.op == io_space_pkg::OP_DATA_LOAD ||
                   req_i.op == io_space_pkg::OP_DATA_STORE) begin
         if (req_i.addr >= `DATA_EXT_BASE) begin
            ext_hit = 1'b1;
         end else if (req_i.addr >= `DATA_IO_OFFSET) begin
            io_hit = 1'b1;
            io_idx = 6'(req_i.addr - `DATA_IO_OFFSET);
         end else begin
            refused = 1'b1;
         end
      end else if (req_i.op == io_space_pkg::OP_IO_READ ||
                   req_i.op == io_space_pkg::OP_IO_WRITE) begin
         io_hit = (req_i.addr <= `IO_TOP);
         refused = !io_hit;
      end else begin
         // Bit instructions never reach past the low 32 registers
         io_hit = (req_i.addr <= `IO_BIT_TOP);
         refused = !io_hit;
      end
   end

   // Byte lanes written: full byte for stores, one bit for bit instructions
   always_comb begin
      onehot = 8'h01 << req_i.bit_sel;
      is_write = 1'b0;
      wsel = `MASK_NONE;
      wval = `MASK_NONE;
      case (req_i.op)
         io_space_pkg::OP_IO_WRITE, io_space_pkg::OP_DATA_STORE: begin
            is_write = 1'b1;
            wsel = `MASK_FULL;
            wval = req_i.wdata;
         end
         io_space_pkg::OP_BIT_SET: begin
            is_write = 1'b1;
            wsel = onehot;
            wval = onehot;
         end
         io_space_pkg::OP_BIT_CLEAR: begin
            is_write = 1'b1;
            wsel = onehot;
            wval = `MASK_NONE;
         end
         default: begin
            is_write = 1'b0;
         end
      endcase
   end

   // One flop group per I/O location
   genvar a;
   generate
      for (a = 0; a < 64; a++) begin : g_io
         localparam logic [5:0] A = 6'(a);
         logic hit;
         logic [7:0] lanes;
         assign hit = io_hit && is_write && (io_idx == A);
         assign lanes = hit ? (wsel & valid_mask(A)) : `MASK_NONE;
         always_ff @(posedge sys_clk_i) begin
            if (!resetn_i) begin
               reg_q[a] <= `REG_RESET;
            end else if (is_pin(A)) begin
               reg_q[a] <= `REG_RESET; // Pin inputs are read-only, read from sync flops
            end else if (is_w1c(A)) begin
               // A hardware set in the same cycle beats the clear
               reg_q[a] <= (reg_q[a] & ~(wval & lanes)) |
                           (hw_set(A, flag_set_i) & valid_mask(A));
            end else begin
               reg_q[a] <= (reg_q[a] & ~lanes) | (wval & lanes);
            end
         end
         assign io_regs_o[a] = reg_q[a];
      end
   endgenerate

   // Extended area, data-space only
   always_ff @(posedge sys_clk_i) begin
      if (!resetn_i) begin
         for (int i = 0; i < EXT_DEPTH; i++) begin
            ext_q[i] <= `REG_RESET;
         end
      end else if (ext_hit && is_write) begin
         ext_q[ext_idx] <= req_i.wdata;
      end
   end

   // Read data; reserved bits come back as zero
   always_comb begin
      rd_byte = `MASK_NONE;
      if (ext_hit) begin
         rd_byte = ext_q[ext_idx];
      end else if (io_hit) begin
         if (io_idx == `OFS_PORT_B_PIN) begin
            rd_byte = pin_b_q;
         end else if (io_idx == `OFS_PORT_C_PIN) begin
            rd_byte = pin_c_q & `MASK_PORT_C;
         end else if (io_idx == `OFS_PORT_D_PIN) begin
            rd_byte = pin_d_q;
         end else begin
            rd_byte = reg_q[io_idx] & valid_mask(io_idx);
         end
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (!resetn_i) begin
         rsp_q <= '0;
      end else begin
         rsp_q.valid <= req_i.valid;
         rsp_q.refused <= refused;
         rsp_q.rdata <= (req_i.valid && !refused) ? rd_byte : `MASK_NONE;
         case (req_i.op)
            io_space_pkg::OP_SKIP_IF_SET: rsp_q.skip <= io_hit && rd_byte[req_i.bit_sel];
            io_space_pkg::OP_SKIP_IF_CLEAR: rsp_q.skip <= io_hit && !rd_byte[req_i.bit_sel];
            default: rsp_q.skip <= 1'b0;
         endcase
      end
   end

   assign rsp_o = rsp_q;

   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (!resetn_i);

   bit_op_range_a: assert property (
      (req_i.valid && req_i.addr > `IO_BIT_TOP && (req_i.op == io_space_pkg::OP_BIT_SET ||
       req_i.op == io_space_pkg::OP_BIT_CLEAR)) |=> rsp_o.refused && rsp_o.valid)
      else $error("bit instruction above low range not refused");

   skip_result_a: assert property (
      (req_i.valid && req_i.op == io_space_pkg::OP_SKIP_IF_SET && io_hit &&
       !is_pin(io_idx) && !is_w1c(io_idx)) |=>
      {7'h00, rsp_o.skip} ==
      $past(((reg_q[io_idx] & valid_mask(io_idx)) >> req_i.bit_sel) & 8'h01))
      else $error("skip result does not follow tested bit");

   flag_w1c_a: assert property (
      (io_hit && is_write && io_idx == `OFS_EXTIRQ_FLAGS && flag_set_i.ext_irq == 8'h00 &&
       (wval & wsel & `MASK_EXTIRQ) == `MASK_EXTIRQ) |=> reg_q[`OFS_EXTIRQ_FLAGS] == 8'h00)
      else $error("writing one did not clear flags");

   flag_set_wins_a: assert property (
      flag_set_i.timer0[0] |=> reg_q[`OFS_TMR0_FLAGS][0])
      else $error("flag event lost against clear");

   bit_only_a: assert property (
      (io_hit && req_i.op == io_space_pkg::OP_BIT_SET && io_idx == `OFS_PORT_B_OUT) |=>
      ((reg_q[`OFS_PORT_B_OUT] ^ $past(reg_q[`OFS_PORT_B_OUT])) &
       ~$past(onehot)) == 8'h00)
      else $error("bit set disturbed other bits");

   io_range_a: assert property (
      (req_i.valid && req_i.op == io_space_pkg::OP_IO_READ && req_i.addr > `IO_TOP) |=>
      rsp_o.refused && rsp_o.rdata == 8'h00)
      else $error("I/O read beyond 0x3F not refused");

   data_mirror_a: assert property (
      (req_i.valid && req_i.op == io_space_pkg::OP_DATA_STORE &&
       req_i.addr == (`DATA_IO_OFFSET + 8'h1E)) |=> reg_q[`OFS_SCRATCH0] == $past(req_i.wdata))
      else $error("data store not mirrored onto I/O register");

   pin_read_a: assert property (
      (req_i.valid && req_i.op == io_space_pkg::OP_IO_READ && req_i.addr == 8'h03) |=>
      rsp_o.rdata == $past(pin_b_q))
      else $error("port pin register read mismatch");

   reserved_zero_a: assert property (
      (req_i.valid && req_i.op == io_space_pkg::OP_IO_READ && req_i.addr == 8'h0C) |=>
      rsp_o.rdata == 8'h00 ##1 reg_q[12] == 8'h00)
      else $error("reserved location not zero");

   rsp_follows_a: assert property (
      req_i.valid |=> rsp_o.valid)
      else $error("request left without an answer");

   idle_quiet_a: assert property (
      !req_i.valid |=>
      !rsp_o.valid && !rsp_o.refused && !rsp_o.skip && rsp_o.rdata == 8'h00)
      else $error("answer fields active without a request");

   data_low_refused_a: assert property (
      (req_i.valid && (req_i.op == io_space_pkg::OP_DATA_LOAD ||
       req_i.op == io_space_pkg::OP_DATA_STORE) && req_i.addr < `DATA_IO_OFFSET) |=>
      rsp_o.refused && rsp_o.rdata == 8'h00)
      else $error("data access below the mirror not refused");

   load_mirror_a: assert property (
      (req_i.valid && req_i.op == io_space_pkg::OP_DATA_LOAD &&
       req_i.addr == (`DATA_IO_OFFSET + 8'h1E)) |=>
      !rsp_o.refused && rsp_o.rdata == $past(reg_q[`OFS_SCRATCH0]))
      else $error("data load not mirrored onto I/O register");

   ext_load_a: assert property (
      (req_i.valid && req_i.op == io_space_pkg::OP_DATA_LOAD &&
       req_i.addr >= `DATA_EXT_BASE) |=>
      !rsp_o.refused && rsp_o.rdata == $past(ext_q[ext_idx]))
      else $error("extended area load mismatch");

   ext_store_a: assert property (
      (req_i.valid && req_i.op == io_space_pkg::OP_DATA_STORE &&
       req_i.addr >= `DATA_EXT_BASE) |=> ext_q[$past(ext_idx)] == $past(req_i.wdata))
      else $error("extended area store lost");

   ext_io_blocked_a: assert property (
      (req_i.valid && (req_i.op == io_space_pkg::OP_IO_READ ||
       req_i.op == io_space_pkg::OP_IO_WRITE) && req_i.addr >= `DATA_EXT_BASE) |=>
      rsp_o.refused && ext_q[$past(ext_idx)] == $past(ext_q[ext_idx]))
      else $error("I/O instruction reached the extended area");

   skip_clear_a: assert property (
      (req_i.valid && req_i.op == io_space_pkg::OP_SKIP_IF_CLEAR && io_hit &&
       !is_pin(io_idx)) |=>
      {7'h00, !rsp_o.skip} ==
      $past(((reg_q[io_idx] & valid_mask(io_idx)) >> req_i.bit_sel) & 8'h01))
      else $error("skip-if-clear result does not follow tested bit");

   skip_range_a: assert property (
      (req_i.valid && req_i.addr > `IO_BIT_TOP && (req_i.op == io_space_pkg::OP_SKIP_IF_SET ||
       req_i.op == io_space_pkg::OP_SKIP_IF_CLEAR)) |=> rsp_o.refused && !rsp_o.skip)
      else $error("skip instruction above low range not refused");

   flag_bit_set_a: assert property (
      (io_hit && req_i.op == io_space_pkg::OP_BIT_SET && io_idx == `OFS_EXTIRQ_FLAGS &&
       flag_set_i.ext_irq == 8'h00) |=>
      reg_q[`OFS_EXTIRQ_FLAGS] ==
      ($past(reg_q[`OFS_EXTIRQ_FLAGS]) & ~(8'h01 << $past(req_i.bit_sel))))
      else $error("bit set on a flag register cleared other flags");

   flag_bit_clear_a: assert property (
      (io_hit && req_i.op == io_space_pkg::OP_BIT_CLEAR && io_idx == `OFS_EXTIRQ_FLAGS &&
       flag_set_i.ext_irq == 8'h00) |=>
      reg_q[`OFS_EXTIRQ_FLAGS] == $past(reg_q[`OFS_EXTIRQ_FLAGS]))
      else $error("bit clear disturbed a status flag");

   port_c_read_a: assert property (
      (req_i.valid && req_i.op == io_space_pkg::OP_IO_READ && req_i.addr == 8'h06) |=>
      rsp_o.rdata == ($past(pin_c_q) & `MASK_PORT_C))
      else $error("port C pin register read mismatch");

endmodule

// ===== tb/core_model.sv
// Processor core model that issues I/O, bit, skip and data-space accesses.
// Assumes the decoder takes a request at one edge and answers at the next.
`timescale 1ns/10ps

module core_model (
   input wire logic sys_clk_i, // Core clock
   output io_space_pkg::core_req_s req_o, // Request to the decoder
   input wire io_space_pkg::core_rsp_s rsp_i // Answer from the decoder
);
   initial begin
      req_o = '0;
   end

   // One request per call; address and write data flip so stale values are never mistaken for data
   task automatic access(input io_space_pkg::core_op_e op, input logic [7:0] ad,
         input logic [7:0] wd, input logic [2:0] bs, output io_space_pkg::core_rsp_s rsp);
      @(posedge sys_clk_i);
      #1;
      req_o = '{valid: 1'b1, op: op, addr: ad, wdata: wd, bit_sel: bs};
      @(posedge sys_clk_i);
      #1;
      rsp = rsp_i;
      req_o.valid = 1'b0;
      req_o.addr = ~ad;
      req_o.wdata = ~wd;
   endtask
endmodule

// ===== tb/test_io_register_space_decoder.sv
// Self-checking bench for the I/O register space decoder.
// Assumes core_model drives the request port; events and pins come from here.
`timescale 1ns/10ps

module test_io_register_space_decoder;
   logic sys_clk_i;
   logic resetn_i;
   io_space_pkg::core_req_s req;
   io_space_pkg::core_rsp_s rsp;
   logic [39:0] ev_bits;
   logic [7:0] pb, pc, pd, m, v;
   logic [63:0][7:0] regs;
   logic [7:0] ref_io [64];
   logic [7:0] ref_ext [256];
   logic [5:0] a;
   logic [2:0] b;
   logic [7:0] d;
   integer seed = 32'h9829FFC9;
   int n_fail = 0;
   int n_compared = 0;
   int cycles = 0;
   logic [5:0] fl_addr [5] = '{6'h15, 6'h16, 6'h17, 6'h1B, 6'h1C};
   logic [5:0] rsv_addr [6] = '{6'h00, 6'h01, 6'h02, 6'h0C, 6'h1F, 6'h3E};

   io_space_pkg::core_rsp_s rsp_w;
   io_register_space_decoder io_register_space_decoder_i (.sys_clk_i(sys_clk_i),
      .resetn_i(resetn_i), .req_i(req), .flag_set_i(io_space_pkg::flag_events_s'(ev_bits)),
      .port_b_pins_i(pb), .port_c_pins_i(pc), .port_d_pins_i(pd), .rsp_o(rsp_w), .io_regs_o(regs));
   core_model core_model_i (.sys_clk_i(sys_clk_i), .req_o(req), .rsp_i(rsp_w));

   function automatic logic [7:0] mask_of(input logic [5:0] ad);
      case (ad)
         6'h04, 6'h05, 6'h0A, 6'h0B, 6'h1E, 6'h20, 6'h21, 6'h26, 6'h27, 6'h28, 6'h2A, 6'h2B,
            6'h22, 6'h2C, 6'h2E, 6'h30: mask_of = 8'hFF;
         6'h07, 6'h08: mask_of = 8'h7F;
         6'h15, 6'h17, 6'h1B: mask_of = 8'h07;
         6'h16: mask_of = 8'h27;
         6'h1C, 6'h1D: mask_of = 8'h03;
         6'h23: mask_of = 8'h83;
         6'h24: mask_of = 8'hF3;
         6'h25: mask_of = 8'hCF;
         6'h2D: mask_of = 8'hC1;
         6'h33, 6'h34: mask_of = 8'h0F;
         6'h35: mask_of = 8'h73;
         default: mask_of = 8'h00;
      endcase
   endfunction

   function automatic bit w1c(input logic [5:0] ad);
      return ad inside {6'h15, 6'h16, 6'h17, 6'h1B, 6'h1C};
   endfunction

   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      n_compared++;
      if (seen !== exp) begin
         n_fail++;
         $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
      end
   endtask

   task automatic acc(input io_space_pkg::core_op_e op, input logic [7:0] ad,
         input logic [7:0] wd, input logic [2:0] bs, input logic refd);
      core_model_i.access(op, ad, wd, bs, rsp);
      check({7'h00, rsp.valid}, 8'h01);
      check({7'h00, rsp.refused}, {7'h00, refd});
   endtask

   // Only mapped addresses are written, reserved bits as zero
   task automatic wr(input logic [5:0] ad, input logic [7:0] wd, input bit dsp);
      logic [7:0] mk;
      mk = mask_of(ad);
      if (dsp) acc(io_space_pkg::OP_DATA_STORE, {2'b00, ad} + 8'h20, wd & mk, 3'h0, 1'b0);
      else acc(io_space_pkg::OP_IO_WRITE, {2'b00, ad}, wd & mk, 3'h0, 1'b0);
      ref_io[ad] = w1c(ad) ? ref_io[ad] & ~(wd & mk) : wd & mk;
      check(regs[ad], ref_io[ad]);
   endtask

   task automatic rd(input logic [5:0] ad, input bit dsp, input logic [7:0] exp);
      if (dsp) acc(io_space_pkg::OP_DATA_LOAD, {2'b00, ad} + 8'h20, 8'h00, 3'h0, 1'b0);
      else acc(io_space_pkg::OP_IO_READ, {2'b00, ad}, 8'h00, 3'h0, 1'b0);
      check(rsp.rdata, exp);
   endtask

   task automatic end_of_test();
      $display("compared %0d, mismatched %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask

   initial begin
      sys_clk_i = 1'b0;
      forever #2 sys_clk_i = ~sys_clk_i;
   end

   // Whole run needs some 2600 cycles
   always @(posedge sys_clk_i) begin
      cycles++;
      if (cycles == 20000) begin
         n_fail++;
         end_of_test();
      end
   end

   initial begin
      resetn_i = 1'b0;
      ev_bits = '0;
      {pb, pc, pd} = 24'($random(seed));
      foreach (ref_io[i]) ref_io[i] = 8'h00;
      foreach (ref_ext[i]) ref_ext[i] = 8'h00;
      repeat (5) @(posedge sys_clk_i);
      #1;
      resetn_i = 1'b1;
      for (int i = 0; i < 64; i++) check(regs[i], 8'h00);
      $display("test reset done");
      repeat (300) begin
         a = 6'($random(seed));
         if (mask_of(a) == 8'h00 || w1c(a)) continue;
         wr(a, 8'($random(seed)), 1'($random(seed)));
         rd(a, 1'($random(seed)), ref_io[a]);
      end
      $display("test read write done");
      repeat (200) begin
         a = 6'($random(seed)) & 6'h1F;
         b = 3'($random(seed));
         m = mask_of(a);
         if (m == 8'h00) continue;
         if ($random(seed) & 1) begin
            acc(io_space_pkg::OP_BIT_SET, {2'b00, a}, 8'h00, b, 1'b0);
            if (w1c(a)) ref_io[a] &= ~(m & (8'h01 << b));
            else ref_io[a] |= m & (8'h01 << b);
         end else begin
            acc(io_space_pkg::OP_BIT_CLEAR, {2'b00, a}, 8'h00, b, 1'b0);
            if (!w1c(a)) ref_io[a] &= ~(8'h01 << b);
         end
         check(regs[a], ref_io[a]);
         acc(io_space_pkg::OP_SKIP_IF_SET, {2'b00, a}, 8'h00, b, 1'b0);
         check({7'h00, rsp.skip}, {7'h00, ref_io[a][b]});
         acc(io_space_pkg::OP_SKIP_IF_CLEAR, {2'b00, a}, 8'h00, b, 1'b0);
         check({7'h00, rsp.skip}, {7'h00, ~ref_io[a][b]});
         a = a | 6'h20;
         acc(io_space_pkg::OP_BIT_SET, {2'b00, a}, 8'h00, b, 1'b1);
         acc(io_space_pkg::OP_SKIP_IF_CLEAR, {2'b00, a}, 8'h00, b, 1'b1);
         check({7'h00, rsp.skip}, 8'h00);
         check(regs[a], ref_io[a]);
      end
      $display("test bit access done");
      foreach (fl_addr[k]) begin
         a = fl_addr[k];
         v = 8'($random(seed));
         @(posedge sys_clk_i);
         #1;
         ev_bits[(4 - k) * 8 +: 8] = v;
         @(posedge sys_clk_i);
         #1;
         ev_bits = '0;
         ref_io[a] |= v & mask_of(a);
         check(regs[a], ref_io[a]);
         wr(a, 8'h00, 1'b0);
         wr(a, 8'($random(seed)), 1'b1);
         rd(a, 1'b0, ref_io[a]);
      end
      // Event and clear in one cycle: the event must win
      fork
         acc(io_space_pkg::OP_IO_WRITE, 8'h15, 8'h01, 3'h0, 1'b0);
         begin
            @(posedge sys_clk_i);
            #1;
            ev_bits[32] = 1'b1;
            @(posedge sys_clk_i);
            #1;
            ev_bits = '0;
         end
      join
      ref_io[6'h15] |= 8'h01;
      check(regs[6'h15], ref_io[6'h15]);
      $display("test flags done");
      repeat (100) begin
         d = 8'h60 + 8'($unsigned($random(seed)) % 160);
         v = 8'($random(seed));
         acc(io_space_pkg::OP_DATA_STORE, d, v, 3'h0, 1'b0);
         ref_ext[d] = v;
         acc(io_space_pkg::OP_IO_WRITE, d, ~v, 3'h0, 1'b1);
         d = 8'h60 + 8'($unsigned($random(seed)) % 160);
         acc(io_space_pkg::OP_DATA_LOAD, d, 8'h00, 3'h0, 1'b0);
         check(rsp.rdata, ref_ext[d]);
         acc(io_space_pkg::OP_IO_READ, d, 8'h00, 3'h0, 1'b1);
         check(rsp.rdata, 8'h00);
         acc(io_space_pkg::OP_DATA_LOAD, d & 8'h1F, 8'h00, 3'h0, 1'b1);
      end
      $display("test extended area done");
      repeat (20) begin
         #0;
         {pb, pc, pd} = 24'($random(seed));
         repeat (4) @(posedge sys_clk_i);
         rd(6'h03, 1'b0, pb);
         rd(6'h03, 1'b1, pb);
         rd(6'h09, 1'b0, pd);
         rd(6'h06, 1'b0, pc & 8'h7F);
         check(regs[3], 8'h00);
      end
      foreach (rsv_addr[k]) rd(rsv_addr[k], 1'b0, 8'h00);
      $display("test ports and reserved done");
      end_of_test();
   end
endmodule
